/* pmic_irq_defs.vh */
// Constants for the interrupt and status register group
`ifndef PMIC_IRQ_DEFS_VH
`define PMIC_IRQ_DEFS_VH
`define OFS_IDENTITY 8'h01
`define OFS_EVENT_FLAGS 8'h02
`define OFS_EVENT_MASKS 8'h03
`define OFS_DIE_HEAT 8'h04
`define OFS_CAUSE 8'h05
`define OFS_RAIL_CAUSE_A 8'hb2
`define OFS_RAIL_CAUSE_B 8'hb3
`define OFS_CRIT_CAUSE 8'hb4
`define OFS_HOT_CAUSE 8'hb5
`define OFS_OVERCURRENT 8'hb6
`define BIT_ERROR 7
`define BIT_POWERDOWN 3
`define BIT_HOT 0
`define FLAGS_RESET 8'h00
`define MASKS_RESET 8'hff
`define MASKS_RSVD 8'h76
`define CAUSE_RESET 4'h0
`define CAUSE_UV 2
`define CAUSE_RAIL 1
`define CAUSE_CRIT 0
`endif

/* sticky_bit.v */
// Sticky event bit with write-one-to-clear and set priority
`timescale 1ns/10ps
module sticky_bit (
  mclk,
  rstn,
  set_evt,
  clr_req,
  q_ff
);
  input wire mclk;
  input wire rstn;
  input wire set_evt;
  input wire clr_req;
  output reg q_ff;
  wire nxt_q;
  // Set wins over a clear in the same cycle
  assign nxt_q = set_evt | (q_ff & ~clr_req);
  always @(posedge mclk) begin
    if (!rstn) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

/* pmic_irq_status_regs.v */
// Interrupt, mask, identity and die temperature registers of the PMIC
// What this block does
// - Error flag bit 7 sets on undervoltage, rail fault, or critical heat.
// - Cause registers 0xB2-0xB6 readable; host clears error flag writing 1.
// - Powerdown flag bit 3 sets on shutdown and stays until host clears.
// - Powerdown flag clears only once no powerdown cause bit remains.
// - Hot die flag bit 0 sets above hot threshold; write 1 clears.
// - Flags register at 2h resets 0; reserved bits read zero.
// - Mask bits 7, 3, 0 read-write; 1 masks the event.
// - Mask register at 3h resets FFh; reserved fields read 7h and 3h.
// - Register 4h bit 0 shows live hot-die level; rest zero.
// - Identity at 1h: revision bits 7-6, variant code bits 5-4.
// - Identity bits 3-0 hold fixed part identifier; writes ignored.
// - Any set powerdown cause bit also sets the powerdown flag.
`timescale 1ns/10ps
`include "pmic_irq_defs.vh"
module pmic_irq_status_regs #(
  parameter [1:0] SILICON_REV = 2'h0,
  parameter [1:0] VARIANT_CODE = 2'h1,
  // Arbitrary part identifier value
  parameter [3:0] PART_ID = 4'h6
) (
  mclk,
  rstn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rdata,
  supply_undervoltage,
  rail_error,
  critical_heat_threshold,
  hot_die_level,
  powerdown_evt,
  rail_error_cause_a,
  rail_error_cause_b,
  crit_heat_cause,
  hot_heat_cause,
  overcurrent_cause,
  irq_n_o,
  irq_n_oe
);
  input wire mclk;
  input wire rstn;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  output reg [7:0] reg_rdata;
  input wire supply_undervoltage;
  input wire rail_error;
  input wire critical_heat_threshold;
  input wire hot_die_level;
  input wire powerdown_evt;
  input wire [7:0] rail_error_cause_a;
  input wire [7:0] rail_error_cause_b;
  input wire [7:0] crit_heat_cause;
  input wire [7:0] hot_heat_cause;
  input wire [7:0] overcurrent_cause;
  output wire irq_n_o;
  output wire irq_n_oe;

  // ==========================================================
  // Address compare, shared by write decode and read select
  function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Write decode; identity, level and cause-status offsets take no writes
  wire wr_flags;
  wire wr_masks;
  wire wr_cause;
  assign wr_flags = reg_wr && addr_hit(reg_addr, `OFS_EVENT_FLAGS);
  assign wr_masks = reg_wr && addr_hit(reg_addr, `OFS_EVENT_MASKS);
  assign wr_cause = reg_wr && addr_hit(reg_addr, `OFS_CAUSE);

  // ==========================================================
  // Powerdown cause register, write one to clear
  reg [3:0] powerdown_cause_register_ff;
  reg [3:0] nxt_cause;
  wire [3:0] cause_set;
  wire [3:0] cause_clr;
  // Bit 3 has no source in this block and always reads zero
  assign cause_set = {1'b0, supply_undervoltage, rail_error, critical_heat_threshold};
  assign cause_clr = wr_cause ? reg_wdata[3:0] : `CAUSE_RESET;
  always @* begin
    // A source still active re-sets its bit over a clearing write
    nxt_cause = cause_set | (powerdown_cause_register_ff & ~cause_clr);
  end
  always @(posedge mclk) begin
    if (!rstn) begin
      powerdown_cause_register_ff <= `CAUSE_RESET;
    end else begin
      powerdown_cause_register_ff <= nxt_cause;
    end
  end

  // ==========================================================
  // Sticky event flags
  wire error_flag;
  wire powerdown_event_flag;
  wire hot_die_flag;
  wire err_set = supply_undervoltage | rail_error | critical_heat_threshold;
  wire pd_set = powerdown_evt | (|cause_set);
  // Clear is refused while a cause bit stays set after this write
  wire pd_clr = wr_flags && reg_wdata[`BIT_POWERDOWN] && (nxt_cause == `CAUSE_RESET);
  wire err_clr;
  wire hot_clr;
  assign err_clr = wr_flags && reg_wdata[`BIT_ERROR];
  assign hot_clr = wr_flags && reg_wdata[`BIT_HOT];
  sticky_bit u_err (
    .mclk(mclk),
    .rstn(rstn),
    .set_evt(err_set),
    .clr_req(err_clr),
    .q_ff(error_flag)
  );
  sticky_bit u_pd (
    .mclk(mclk),
    .rstn(rstn),
    .set_evt(pd_set),
    .clr_req(pd_clr),
    .q_ff(powerdown_event_flag)
  );
  sticky_bit u_hot (
    .mclk(mclk),
    .rstn(rstn),
    .set_evt(hot_die_level),
    .clr_req(hot_clr),
    .q_ff(hot_die_flag)
  );

  // ==========================================================
  // Mask register
  reg error_flag_mask_ff;
  reg powerdown_flag_mask_ff;
  reg hot_die_mask_ff;
  // Every event starts masked, so the pin stays quiet until the host opts in
  wire [7:0] masks_reset = `MASKS_RESET;
  always @(posedge mclk) begin
    if (!rstn) begin
      error_flag_mask_ff <= masks_reset[`BIT_ERROR];
      powerdown_flag_mask_ff <= masks_reset[`BIT_POWERDOWN];
      hot_die_mask_ff <= masks_reset[`BIT_HOT];
    end else if (wr_masks) begin
      error_flag_mask_ff <= reg_wdata[`BIT_ERROR];
      powerdown_flag_mask_ff <= reg_wdata[`BIT_POWERDOWN];
      hot_die_mask_ff <= reg_wdata[`BIT_HOT];
    end
  end

  // ==========================================================
  // Register images as the host sees them
  wire [7:0] identity_image;
  wire [7:0] flags_image;
  wire [7:0] masks_image;
  wire [7:0] heat_image;
  wire [7:0] cause_image;
  assign identity_image = {SILICON_REV, VARIANT_CODE, PART_ID};
  assign flags_image = {error_flag, 3'h0, powerdown_event_flag, 2'h0, hot_die_flag};
  assign masks_image = `MASKS_RSVD | {error_flag_mask_ff, 3'h0, powerdown_flag_mask_ff,
    2'h0, hot_die_mask_ff};
  assign heat_image = {7'h00, hot_die_level};
  assign cause_image = {4'h0, powerdown_cause_register_ff};

  // ==========================================================
  // Interrupt pin, pulled low only
  // Reserved flag bits are zero, so the reserved ones of the mask image drop out
  function unmasked_any;
    input [7:0] flags;
    input [7:0] masks;
    begin
      unmasked_any = |(flags & ~masks);
    end
  endfunction
  wire irq_active;
  assign irq_active = unmasked_any(flags_image, masks_image);
  // Open drain: data is always low, only the enable moves
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_active;

  // ==========================================================
  // Read data, registered; unmapped offsets read zero
  reg [7:0] nxt_rdata;
  always @* begin
    if (addr_hit(reg_addr, `OFS_IDENTITY)) begin
      nxt_rdata = identity_image;
    end else if (addr_hit(reg_addr, `OFS_EVENT_FLAGS)) begin
      nxt_rdata = flags_image;
    end else if (addr_hit(reg_addr, `OFS_EVENT_MASKS)) begin
      nxt_rdata = masks_image;
    end else if (addr_hit(reg_addr, `OFS_DIE_HEAT)) begin
      nxt_rdata = heat_image;
    end else if (addr_hit(reg_addr, `OFS_CAUSE)) begin
      nxt_rdata = cause_image;
    end else if (addr_hit(reg_addr, `OFS_RAIL_CAUSE_A)) begin
      nxt_rdata = rail_error_cause_a;
    end else if (addr_hit(reg_addr, `OFS_RAIL_CAUSE_B)) begin
      nxt_rdata = rail_error_cause_b;
    end else if (addr_hit(reg_addr, `OFS_CRIT_CAUSE)) begin
      nxt_rdata = crit_heat_cause;
    end else if (addr_hit(reg_addr, `OFS_HOT_CAUSE)) begin
      nxt_rdata = hot_heat_cause;
    end else if (addr_hit(reg_addr, `OFS_OVERCURRENT)) begin
      nxt_rdata = overcurrent_cause;
    end else begin
      nxt_rdata = 8'h00;
    end
  end
  always @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end
endmodule

/* irq_pullup.sv */
// Board pull-up on the open-drain interrupt line
`timescale 1ns/10ps
module irq_pullup (
  input wire irq_n_o,
  input wire irq_n_oe,
  output wire irq_pin
);
  // Released line goes to the pull-up level, never the last value
  assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
endmodule

/* pmic_irq_sva.sv */
// Checker for the event register group
`timescale 1ns/10ps
module pmic_irq_sva (
  input wire mclk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  input wire supply_undervoltage,
  input wire rail_error,
  input wire critical_heat_threshold,
  input wire hot_die_level,
  input wire powerdown_evt,
  input wire irq_n_oe
);
  // ==========
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire err_ev = supply_undervoltage | rail_error | critical_heat_threshold;
  wire any_ev = err_ev | hot_die_level | powerdown_evt;
  // Event seen, then flags address held so the set value is read back
  sequence flags_read;
    (reg_addr == 8'h02) ##1 (reg_addr == 8'h02);
  endsequence
  a_error_sets: assert property (err_ev ##0 flags_read |=> reg_rdata[7])
    else $error("error flag not set");
  a_down_sets: assert property ((err_ev | powerdown_evt) ##0 flags_read |=> reg_rdata[3])
    else $error("powerdown flag not set");
  a_hot_sets: assert property (hot_die_level ##0 flags_read |=> reg_rdata[0])
    else $error("hot flag not set");
  a_flags_rsvd: assert property (reg_addr == 8'h02 |=> (reg_rdata & 8'h76) == 8'h00)
    else $error("flag reserved bits set");
  a_mask_rsvd: assert property (reg_addr == 8'h03 |=> (reg_rdata & 8'h76) == 8'h76)
    else $error("mask reserved bits wrong");
  a_heat_live: assert property (reg_addr == 8'h04 |=> reg_rdata == {7'h00, $past(hot_die_level)})
    else $error("heat level wrong");
  a_irq_rise: assert property (!irq_n_oe && !any_ev && !reg_wr |=> !irq_n_oe)
    else $error("interrupt without cause");
  a_irq_hold: assert property (irq_n_oe && !reg_wr |=> irq_n_oe)
    else $error("interrupt dropped without write");
endmodule
bind pmic_irq_status_regs pmic_irq_sva chk_u (.*);

/* pmic_irq_status_regs_tb_top.sv */
// Register-level tests of the event register group
`timescale 1ns/10ps
module pmic_irq_status_regs_tb_top;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg [4:0] ev = 5'h00;
  reg [7:0] cs = 8'h5a;
  reg [7:0] k;
  wire [7:0] reg_rdata;
  wire irq_n_o;
  wire irq_n_oe;
  wire irq_pin;
  integer num_errors = 0;
  integer tests_run = 0;
  // Variant and part identifier arbitrary, chosen away from the defaults; revision left at its default
  pmic_irq_status_regs #(.VARIANT_CODE(2'h2), .PART_ID(4'h5)) dut_u (.*,
    .supply_undervoltage(ev[4]), .rail_error(ev[3]), .critical_heat_threshold(ev[2]),
    .hot_die_level(ev[1]), .powerdown_evt(ev[0]), .rail_error_cause_a(cs),
    .rail_error_cause_b(cs ^ 8'h11), .crit_heat_cause(cs ^ 8'h22),
    .hot_heat_cause(cs ^ 8'h33), .overcurrent_cause(cs ^ 8'h44));
  irq_pullup pu_u (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_pin(irq_pin));
  initial forever #50 mclk = ~mclk;
  // ==========
  // Access tasks
  task chk(input [7:0] g, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        $display("[ERR] %0t got %h exp %h", $time, g, e);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk) reg_addr <= a;
      @(posedge mclk);
      #1 chk(reg_rdata, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk) begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
      end
      @(posedge mclk) reg_wr <= 1'b0;
    end
  endtask
  task pulse(input [4:0] v);
    begin
      @(posedge mclk) ev <= v;
      @(posedge mclk) ev <= 5'h00;
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h02, 8'h00);
    rd(8'h03, 8'hff);
    rd(8'h04, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h25);
    rd(8'h20, 8'h00);
    for (k = 8'h00; k < 8'h05; k = k + 8'h01)
      rd(8'hb2 + k, cs ^ (8'h11 * k));
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h76);
    // Flags address left standing so the checker sees each event land
    rd(8'h02, 8'h00);
    for (k = 8'h00; k < 8'h03; k = k + 8'h01) begin
      pulse(5'h04 << k);
      rd(8'h02, 8'h88);
      rd(8'h05, 8'h01 << k);
      chk({7'h00, irq_pin}, 8'h00);
      wr(8'h02, 8'h88);
      rd(8'h02, 8'h08);
      wr(8'h05, 8'h07);
      rd(8'h05, 8'h00);
      wr(8'h02, 8'h08);
      rd(8'h02, 8'h00);
      chk({7'h00, irq_pin}, 8'h01);
    end
    pulse(5'h01);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h08);
    wr(8'h02, 8'h08);
    rd(8'h02, 8'h00);
    @(posedge mclk) ev <= 5'h02;
    rd(8'h04, 8'h01);
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h01);
    @(posedge mclk) ev <= 5'h00;
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h00);
    wr(8'h03, 8'hff);
    pulse(5'h01);
    rd(8'h02, 8'h08);
    chk({7'h00, irq_pin}, 8'h01);
    wrap_up;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
endmodule
